// *** src/arlc_defs.svh ***
// constants for the restart and load-ok flow control block
`ifndef ARLC_DEFS_SVH
`define ARLC_DEFS_SVH
`define ARLC_SEQUENCE_TRIGGER_BIT_BIT 6
`define ARLC_RESTART_REQUEST_BIT_BIT 5
`define ARLC_LOAD_OK_BIT_BIT 4
`define ARLC_EIF_LOAD_OK_BIT_BIT 1
`define ARLC_FLW_RESET 8'h00
`define ARLC_SRC_BUS 2'h1
`define ARLC_SRC_IF 2'h2
`endif

// *** src/arlc_pkg.sv ***
// types for the restart and load-ok flow control block
package arlc_pkg;
	typedef struct packed {
		logic adc_en;
		logic trigger_mode;
		logic dbuf_mode;
		logic [1:0] src_sel;
	} arlc_cfg_t;
	typedef struct packed {
		logic restart;
		logic list_ready;
	} arlc_strobe_t;
	typedef struct packed {
		logic busy;
		logic cmd_loaded;
		logic eol;
		logic abort;
		logic sequence_trigger_bit_clear;
	} arlc_seq_t;
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_FETCH
	} arlc_state_t;
endpackage

// *** src/arlc_sticky.sv ***
// sticky flag: set wins over clear, kill wins over both
`timescale 1ns/10ps
`default_nettype none
module arlc_sticky
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic clr_i,
	input wire logic kill_i,
	output logic q_o
);
	logic q_nxt;
	assign q_nxt = kill_i ? 1'b0 : (set_i ? 1'b1 : (clr_i ? 1'b0 : q_o));
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			q_o <= 1'b0;
		else
			q_o <= q_nxt;
	end
endmodule // arlc_sticky
`default_nettype wire

// *** src/arlc_flow_ctrl.sv ***
// restart and load-ok flow control with list swap
`timescale 1ns/10ps
`default_nettype none
`include "arlc_defs.svh"
module arlc_flow_ctrl
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire arlc_pkg::arlc_cfg_t cfg_i,
	input wire logic stop_exit_i,
	input wire logic soft_reset_i,
	input wire logic flw_wr_i,
	input wire logic [7:0] flw_wdata_i,
	input wire logic eif_wr_i,
	input wire logic [7:0] eif_wdata_i,
	input wire arlc_pkg::arlc_strobe_t strobe_i,
	input wire arlc_pkg::arlc_seq_t seq_i,
	output logic [7:0] flw_rdata_o,
	output logic [7:0] eif_rdata_o,
	output logic fetch_top_o,
	output logic list_swap_o,
	output logic restart_overrun_o
);
	import arlc_pkg::*;

	////////////////////////////////////////////////////////////////
	// state
	logic restart_request_bit_q;
	logic load_ok_bit_q;
	logic sequence_trigger_bit_q;
	logic eif_q;
	logic first_r;
	logic first_nxt;
	logic abort_seen_r;
	logic abort_seen_nxt;
	logic rs_d_r;
	logic fetch_r;
	logic fetch_nxt;
	logic swap_r;
	logic swap_nxt;
	logic ovr_r;
	logic ovr_nxt;
	arlc_state_t state_r;
	arlc_state_t state_nxt;

	////////////////////////////////////////////////////////////////
	// request decode
	wire src_bus = (cfg_i.src_sel == `ARLC_SRC_BUS);
	wire src_if = (cfg_i.src_sel == `ARLC_SRC_IF);
	wire bus_restart_request_bit = flw_wr_i & src_bus & flw_wdata_i[`ARLC_RESTART_REQUEST_BIT_BIT];
	wire bus_load_ok_bit = bus_restart_request_bit & flw_wdata_i[`ARLC_LOAD_OK_BIT_BIT];
	wire if_restart_request_bit = src_if & strobe_i.restart & ~rs_d_r;
	wire if_load_ok_bit = if_restart_request_bit & strobe_i.list_ready;
	wire req = (bus_restart_request_bit | if_restart_request_bit) & cfg_i.adc_en;
	wire restart_request_bit_set = req & ~restart_request_bit_q;
	wire load_ok_bit_set = restart_request_bit_set & (bus_load_ok_bit | if_load_ok_bit) & cfg_i.dbuf_mode;
	wire sequence_trigger_bit_set = restart_request_bit_set & cfg_i.trigger_mode & (seq_i.eol | seq_i.abort);
	wire done = (state_r == ST_FETCH) & seq_i.cmd_loaded;
	wire off = ~cfg_i.adc_en | soft_reset_i;
	wire load_ok_bit_off = off | ~cfg_i.dbuf_mode;
	wire first_now = first_r | stop_exit_i;
	wire abort_now = seq_i.abort | abort_seen_r;
	wire eif_set = restart_request_bit_set & ~cfg_i.trigger_mode & ~load_ok_bit_q & ~load_ok_bit_set
		& ~abort_now & ~first_now;
	wire eif_clr = eif_wr_i & eif_wdata_i[`ARLC_EIF_LOAD_OK_BIT_BIT];

	////////////////////////////////////////////////////////////////
	// flag bits
	arlc_sticky u_restart_request_bit
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(restart_request_bit_set),
		.clr_i(done),
		.kill_i(off),
		.q_o(restart_request_bit_q)
	);
	arlc_sticky u_load_ok_bit
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(load_ok_bit_set),
		.clr_i(done),
		.kill_i(load_ok_bit_off),
		.q_o(load_ok_bit_q)
	);
	arlc_sticky u_sequence_trigger_bit
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(sequence_trigger_bit_set),
		.clr_i(seq_i.sequence_trigger_bit_clear),
		.kill_i(off),
		.q_o(sequence_trigger_bit_q)
	);
	arlc_sticky u_eif
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(eif_set),
		.clr_i(eif_clr),
		.kill_i(off),
		.q_o(eif_q)
	);

	////////////////////////////////////////////////////////////////
	// fetch sequencing
	wire fetch_go = restart_request_bit_q & ~seq_i.busy & ~off;
	wire fetch_cut = off;
	wire fetch_end = seq_i.cmd_loaded & ~off;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (fetch_go)
					state_nxt = ST_FETCH;
			end
			ST_FETCH:
			begin
				if (fetch_cut | fetch_end)
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_comb
	begin
		fetch_nxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				fetch_nxt = fetch_go;
			end
			ST_FETCH:
			begin
				fetch_nxt = ~fetch_cut & ~fetch_end;
			end
			default:
			begin
				fetch_nxt = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		swap_nxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				swap_nxt = 1'b0;
			end
			ST_FETCH:
			begin
				swap_nxt = fetch_end & load_ok_bit_q;
			end
			default:
			begin
				swap_nxt = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// overrun, first restart and abort memory
	wire ovr_bus = bus_restart_request_bit & cfg_i.adc_en & restart_request_bit_q;
	wire ovr_if = if_restart_request_bit & cfg_i.adc_en & restart_request_bit_q;
	wire first_mark = soft_reset_i | stop_exit_i | ~cfg_i.adc_en;
	wire first_keep = restart_request_bit_set ? 1'b0 : first_r;
	wire abort_drop = off | restart_request_bit_set;

	// held while disabled so the first restart after enable is spared
	assign first_nxt = first_mark ? 1'b1 : first_keep;
	// remembers an abort request that came before the restart
	assign abort_seen_nxt = abort_drop ? 1'b0 : abort_now;
	assign ovr_nxt = ovr_bus | ovr_if;

	////////////////////////////////////////////////////////////////
	// fetch state
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// fetch request
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fetch_r <= 1'b0;
		end
		else
		begin
			fetch_r <= fetch_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// list swap pulse
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			swap_r <= 1'b0;
		end
		else
		begin
			swap_r <= swap_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// overrun pulse
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ovr_r <= 1'b0;
		end
		else
		begin
			ovr_r <= ovr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// first restart marker
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			first_r <= 1'b1;
		end
		else
		begin
			first_r <= first_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// restart strobe edge memory
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rs_d_r <= 1'b0;
		end
		else
		begin
			rs_d_r <= strobe_i.restart;
		end
	end

	////////////////////////////////////////////////////////////////
	// abort memory
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			abort_seen_r <= 1'b0;
		end
		else
		begin
			abort_seen_r <= abort_seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	always_comb
	begin
		flw_rdata_o = `ARLC_FLW_RESET;
		flw_rdata_o[`ARLC_SEQUENCE_TRIGGER_BIT_BIT] = sequence_trigger_bit_q;
		flw_rdata_o[`ARLC_RESTART_REQUEST_BIT_BIT] = restart_request_bit_q;
		flw_rdata_o[`ARLC_LOAD_OK_BIT_BIT] = load_ok_bit_q;
	end

	always_comb
	begin
		eif_rdata_o = 8'h00;
		eif_rdata_o[`ARLC_EIF_LOAD_OK_BIT_BIT] = eif_q;
	end
	assign fetch_top_o = fetch_r;
	assign list_swap_o = swap_r;
	assign restart_overrun_o = ovr_r;
endmodule // arlc_flow_ctrl
`default_nettype wire

// *** tb/arlc_seq_model.sv ***
// sequencer model answering fetches from list top
`timescale 1ns/10ps
`default_nettype none
module arlc_seq_model
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic fetch_top_i,
	input wire logic [3:0] wait_i,
	input wire arlc_pkg::arlc_seq_t ctl_i,
	output var arlc_pkg::arlc_seq_t seq_o
);
	import arlc_pkg::*;
	logic [3:0] cnt_r;
	logic done_r;
	wire cmd_w = fetch_top_i && !done_r && cnt_r == wait_i;
	assign seq_o = '{ctl_i.busy, cmd_w, ctl_i.eol, ctl_i.abort, ctl_i.sequence_trigger_bit_clear};
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r <= fetch_top_i ? cnt_r + 4'h1 : 4'h0;
			done_r <= fetch_top_i && (done_r || cmd_w);
		end
	end
endmodule // arlc_seq_model
`default_nettype wire

// *** tb/arlc_flow_ctrl_sva.sv ***
// checker for restart and load-ok flow control
`timescale 1ns/10ps
`default_nettype none
module arlc_flow_ctrl_sva
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire arlc_pkg::arlc_cfg_t cfg_i,
	input wire logic soft_reset_i,
	input wire logic flw_wr_i,
	input wire logic [7:0] flw_wdata_i,
	input wire arlc_pkg::arlc_strobe_t strobe_i,
	input wire arlc_pkg::arlc_seq_t seq_i,
	input wire logic [7:0] flw_rdata_o,
	input wire logic [7:0] eif_rdata_o,
	input wire logic fetch_top_o,
	input wire logic list_swap_o,
	input wire logic restart_overrun_o
);
	import arlc_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////
	a_fetch_list_top: assert property ($rose(flw_rdata_o[5]) && !seq_i.busy && cfg_i.adc_en |-> ##[0:2] fetch_top_o)
		else $error("no fetch");
	a_restart_clears: assert property (fetch_top_o && seq_i.cmd_loaded |=> !flw_rdata_o[5])
		else $error("restart kept");
	a_enable_kills: assert property (!cfg_i.adc_en |=> !flw_rdata_o[5] && !flw_rdata_o[4])
		else $error("set while off");
	a_bus_overrun: assert property (flw_wr_i && cfg_i.src_sel == 2'h1 && cfg_i.adc_en && flw_wdata_i[5] && flw_rdata_o[5]
		|=> restart_overrun_o)
		else $error("no overrun");
	a_sequence_trigger_bit_with_restart_request_bit: assert property ($rose(flw_rdata_o[5]) && $past(cfg_i.trigger_mode) && $past(seq_i.eol) |-> flw_rdata_o[6])
		else $error("no trigger");
	a_swap_clears_ok: assert property (fetch_top_o && seq_i.cmd_loaded && flw_rdata_o[4] && cfg_i.adc_en && !soft_reset_i
		|=> list_swap_o && !flw_rdata_o[4])
		else $error("no swap");
	a_load_ok_bit_no_dbuf: assert property (!cfg_i.dbuf_mode |=> !flw_rdata_o[4])
		else $error("load-ok without dbuf");
	a_load_ok_bit_needs_restart_request_bit: assert property (flw_wr_i && cfg_i.src_sel == 2'h1 && !flw_wdata_i[5] && !flw_rdata_o[4] |=> !flw_rdata_o[4])
		else $error("load-ok alone");
	a_eif_kill: assert property (!cfg_i.adc_en || soft_reset_i |=> !eif_rdata_o[1])
		else $error("flag kept");
	a_other_source: assert property (cfg_i.src_sel != 2'h1 && !strobe_i.restart && !flw_rdata_o[5] |=> !flw_rdata_o[5])
		else $error("wrong source");
endmodule // arlc_flow_ctrl_sva
bind arlc_flow_ctrl arlc_flow_ctrl_sva i_sva (.*);
`default_nettype wire

// *** tb/arlc_flow_ctrl_bench.sv ***
// bench for restart and load-ok flow control
`timescale 1ns/10ps
`default_nettype none
module arlc_flow_ctrl_bench;
	import arlc_pkg::*;
	logic clock_i = 0, rst_i = 1, flw_wr_i = 0, eif_wr_i = 0, r, fetch_top_o, list_swap_o, restart_overrun_o;
	logic [7:0] flw_wdata_i = 0, eif_wdata_i = 0, flw_rdata_o, eif_rdata_o;
	logic [3:0] wait_len = 0;
	logic stop_exit_i = 0, soft_reset_i = 0;
	arlc_cfg_t cfg_i = '{1'b1, 1'b0, 1'b1, 2'h1};
	arlc_strobe_t strobe_i = '0;
	arlc_seq_t ctl = '0, seq_i;
	logic [1:0] q[$];
	int err_count = 0, checked = 0;
	always #20 clock_i = ~clock_i;
	arlc_seq_model i_seq (.clock_i, .rst_i, .fetch_top_i(fetch_top_o), .wait_i(wait_len), .ctl_i(ctl), .seq_o(seq_i));
	arlc_flow_ctrl i_dut (.clock_i, .rst_i, .cfg_i, .stop_exit_i, .soft_reset_i, .flw_wr_i, .flw_wdata_i,
		.eif_wr_i, .eif_wdata_i, .strobe_i, .seq_i, .flw_rdata_o, .eif_rdata_o, .fetch_top_o, .list_swap_o, .restart_overrun_o);
	//////////////////////////////////////////////////
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task stop_test;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] d, input int n);
		@(posedge clock_i);
		flw_wr_i <= 1;
		flw_wdata_i <= d;
		wait_len <= 4'($urandom % 4);
		repeat (n) @(posedge clock_i);
		flw_wr_i <= 0;
		#1;
	endtask
	task fin;
		repeat (20) if (fetch_top_o || flw_rdata_o[5]) @(posedge clock_i);
		#1;
	endtask
	always @(negedge clock_i) if (list_swap_o || restart_overrun_o)
		chk({6'h0, list_swap_o, restart_overrun_o}, {6'h0, q.size() ? q.pop_front() : 2'h3});
	initial
	begin
		#100000;
		err_count++;
		stop_test;
	end
	initial
	begin
		void'($urandom(2));
		repeat (8) @(posedge clock_i);
		rst_i <= 0;
		#1 chk(flw_rdata_o, 8'h00);
		q.push_back(2'b10);
		wr(8'h30, 1);
		chk(flw_rdata_o, 8'h30);
		fin;
		chk(flw_rdata_o, 8'h00);
		q.push_back(2'b01);
		wr(8'h20, 2);
		fin;
		chk(eif_rdata_o, 8'h02);
		@(posedge clock_i) eif_wr_i <= 1;
		eif_wdata_i <= 8'h02;
		@(posedge clock_i) eif_wr_i <= 0;
		#1 chk(eif_rdata_o, 8'h00);
		wr(8'h10, 1);
		chk(flw_rdata_o, 8'h00);
		cfg_i.src_sel <= 2'h2;
		wr(8'h20, 1);
		chk(flw_rdata_o, 8'h00);
		r = 1'($urandom);
		if (r) q.push_back(2'b10);
		@(posedge clock_i) strobe_i <= '{1'b1, r};
		@(posedge clock_i) strobe_i <= '0;
		#1 chk(flw_rdata_o, {3'h1, r, 4'h0});
		fin;
		chk(eif_rdata_o, {6'h0, !r, 1'b0});
		@(posedge clock_i) cfg_i.src_sel <= 2'h1;
		wr(8'h20, 1);
		fin;
		chk(eif_rdata_o, 8'h02);
		@(posedge clock_i) soft_reset_i <= 1;
		@(posedge clock_i) soft_reset_i <= 0;
		#1 chk(eif_rdata_o, 8'h00);
		wr(8'h20, 1);
		fin;
		chk(eif_rdata_o, 8'h00);
		@(posedge clock_i) stop_exit_i <= 1;
		@(posedge clock_i) stop_exit_i <= 0;
		wr(8'h20, 1);
		fin;
		chk(eif_rdata_o, 8'h00);
		@(posedge clock_i) ctl.abort <= 1;
		wr(8'h20, 1);
		fin;
		chk(eif_rdata_o, 8'h00);
		@(posedge clock_i) ctl.abort <= 0;
		cfg_i <= '{1'b1, 1'b1, 1'b0, 2'h1};
		ctl.eol <= 1;
		wr(8'h20, 1);
		chk(flw_rdata_o, 8'h60);
		fin;
		chk(flw_rdata_o, 8'h40);
		@(posedge clock_i) ctl.sequence_trigger_bit_clear <= 1;
		@(posedge clock_i) ctl.sequence_trigger_bit_clear <= 0;
		#1 chk(flw_rdata_o, 8'h00);
		@(posedge clock_i) cfg_i.adc_en <= 0;
		repeat (2) @(posedge clock_i);
		#1 chk(flw_rdata_o, 8'h00);
		wr(8'h20, 1);
		chk(flw_rdata_o, 8'h00);
		@(posedge clock_i) cfg_i <= '{1'b1, 1'b0, 1'b0, 2'h1};
		wr(8'h20, 1);
		fin;
		chk(eif_rdata_o, 8'h00);
		chk(8'(q.size()), 8'h00);
		stop_test;
	end
endmodule // arlc_flow_ctrl_bench
`default_nettype wire
